// ---- sed_pkg.sv ----
// Package for the servo enable and direction block: setting fields and constants.
// Assumes a single 50 MHz drive clock and a synchronous power-on reset.
package sed_pkg;
  // Basic function setting: lowest digit selects servo enable source
  localparam logic [3:0] SED_SON_EXTERNAL   = 4'h0;
  localparam logic [3:0] SED_SON_AUTOMATIC  = 4'h1;
  localparam logic [3:0] SED_DIGIT_RESET    = 4'h0;
  localparam int         SED_DIGIT0_LSB     = 0;
  localparam int         SED_DIGIT_WIDTH    = 4;
  // Direction digit position within the basic function setting
  localparam int         SED_DIR_LSB        = 4;
  localparam logic       SED_DIR_RESET      = 1'b0;
  // Default servo enable terminal number
  localparam int         SED_SON_TERM_RESET = 0;
  // Motor excitation state machine
  typedef enum logic [1:0] {
    SED_OFF  = 2'b00,
    SED_RUN  = 2'b01
  } sed_state_type;
endpackage

// ---- sed_servo_enable.sv ----
// Servo enable selection, terminal routing and rotation direction reversal.
// Assumes inputs synchronous to i_clk; settings are latched at reset release only.
// Terminal inputs are active low levels; terminals that are not selected are ignored.
// Automatic enable mode excites the motor right after ready, with no host consent.
`timescale 1ns/10ps

// Summary of operation
// - While the selected enable terminal is low and servo ready is asserted the motor is powered and references pass.
// - In external mode, while the selected enable terminal is high motor power is off and references are blocked.
// - Setting digit 0 equal to 0 makes the block honour the external enable terminal.
// - Setting digit 0 equal to 1 ignores the terminal and excites once servo ready is asserted.
// - The enable selection setting is captured only at power-up, later changes are ignored.
// - A terminal number setting chooses which physical input carries the enable function.
// - A direction setting reverses the commanded rotation inside the drive.
// - Encoder pulse output and analog monitor polarity are never altered by the direction.
// - With the default direction a forward reference gives counterclockwise rotation.
module sed_servo_enable
  import sed_pkg::*;
#(
  parameter int N_TERM = 8
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  input  wire logic [15:0]                i_basic_function_select,
  input  wire logic [$clog2(N_TERM)-1:0]  i_son_term_sel,
  input  wire logic [N_TERM-1:0]          i_term_n,
  input  wire logic                       i_servo_ready,
  input  wire logic                       i_ref_fwd,
  input  wire logic                       i_ref_valid,
  input  wire logic                       i_enc_a,
  input  wire logic                       i_enc_b,
  input  wire logic                       i_mon_sign,
  output logic                            o_excite,
  output logic                            o_ref_valid,
  output logic                            o_ccw,
  output logic                            o_enc_a,
  output logic                            o_enc_b,
  output logic                            o_mon_sign
);

  localparam int TW = $clog2(N_TERM);

  logic                 cfg_done_q;
  logic [3:0]           son_mode_q;
  logic                 dir_rev_q;
  logic [TW-1:0]        term_q;
  logic                 son_n_q;
  sed_state_type        state_q;
  logic                 son_active;
  logic                 run_ok;

  // True when the latched setting selects automatic enable
  function automatic logic sed_is_auto(input logic [3:0] mode);
    return mode == SED_SON_AUTOMATIC;
  endfunction

  // Latch settings once after reset release; later changes wait for a power cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg_done_q <= 1'b0;
      son_mode_q <= SED_DIGIT_RESET;
      dir_rev_q  <= SED_DIR_RESET;
      term_q     <= TW'(SED_SON_TERM_RESET);
    end else if (!cfg_done_q) begin
      // Capture once so an edit cannot change behaviour while the motor turns
      cfg_done_q <= 1'b1;
      son_mode_q <= i_basic_function_select[SED_DIGIT0_LSB +: SED_DIGIT_WIDTH];
      dir_rev_q  <= i_basic_function_select[SED_DIR_LSB];
      term_q     <= i_son_term_sel;
    end
  end

  // Sample the routed enable terminal
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      son_n_q <= 1'b1;
    end else begin
      son_n_q <= i_term_n[term_q];
    end
  end

  // Enable source: external terminal or automatic once ready
  always_comb begin
    if (sed_is_auto(son_mode_q)) begin
      son_active = i_servo_ready;
    end else begin
      son_active = !son_n_q && i_servo_ready;
    end
  end

  // Excitation state
  always_ff @(posedge i_clk) begin
    if (i_srst || !cfg_done_q) begin
      state_q <= SED_OFF;
    end else begin
      // A lost enable or ready drops the run state at once, with no delay
      unique case (state_q)
        SED_OFF: begin
          if (son_active) begin
            state_q <= SED_RUN;
          end
        end
        SED_RUN: begin
          if (!son_active) begin
            state_q <= SED_OFF;
          end
        end
        default: begin
          state_q <= SED_OFF;
        end
      endcase
    end
  end

  // Motor may be powered this cycle
  assign run_ok = (state_q == SED_RUN) && son_active;

  // Motor power follows the run state and a live enable
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_excite <= 1'b0;
    end else begin
      o_excite <= run_ok;
    end
  end

  // References pass only while powered, so a late enable never starts motion
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ref_valid <= 1'b0;
    end else begin
      o_ref_valid <= run_ok && i_ref_valid;
    end
  end

  // Direction reversal acts on the command only
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ccw <= 1'b1;
    end else begin
      o_ccw <= i_ref_fwd ^ dir_rev_q;
    end
  end

  // Feedback and monitor pass through untouched by direction
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_enc_a    <= 1'b0;
      o_enc_b    <= 1'b0;
      o_mon_sign <= 1'b0;
    end else begin
      o_enc_a    <= i_enc_a;
      o_enc_b    <= i_enc_b;
      o_mon_sign <= i_mon_sign;
    end
  end

  // Enable source and power checks
  a_off_when_high: assert property (@(posedge i_clk) disable iff (i_srst)
    (son_mode_q == SED_SON_EXTERNAL && son_n_q) |=> !o_excite)
    else $error("excitation while enable high");
  a_on_when_low: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_q == SED_RUN && son_active) |=> o_excite)
    else $error("no excitation while enabled");
  a_auto_mode: assert property (@(posedge i_clk) disable iff (i_srst)
    (cfg_done_q && son_mode_q == SED_SON_AUTOMATIC && i_servo_ready)[*3] |=> o_excite)
    else $error("auto mode did not excite");
  a_ext_mode: assert property (@(posedge i_clk) disable iff (i_srst)
    (son_mode_q == SED_SON_EXTERNAL && son_n_q) |=> (state_q == SED_OFF))
    else $error("external enable ignored");

  // Setting capture and terminal routing checks
  a_cfg_frozen: assert property (@(posedge i_clk) disable iff (i_srst)
    $past(cfg_done_q) |-> $stable(son_mode_q) && $stable(dir_rev_q))
    else $error("setting changed without power cycle");
  a_term_route: assert property (@(posedge i_clk) disable iff (i_srst)
    cfg_done_q |=> son_n_q == $past(i_term_n[term_q]))
    else $error("wrong enable terminal");

  // Direction and feedback polarity checks; the reset edge itself is not a transfer
  a_dir_map: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_srst |=> o_ccw == ($past(i_ref_fwd) ^ $past(dir_rev_q)))
    else $error("direction mapping wrong");
  a_default_ccw: assert property (@(posedge i_clk) disable iff (i_srst)
    (!dir_rev_q && i_ref_fwd) |=> o_ccw)
    else $error("forward not counterclockwise");
  a_enc_pass: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_srst |=> o_enc_a == $past(i_enc_a) && o_enc_b == $past(i_enc_b)
      && o_mon_sign == $past(i_mon_sign))
    else $error("feedback polarity changed");

  // Reference gating and turn-off timing checks
  a_ref_gated: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_excite |-> !o_ref_valid)
    else $error("reference passed without power");
  a_fast_off: assert property (@(posedge i_clk) disable iff (i_srst)
    (son_mode_q == SED_SON_EXTERNAL && $rose(son_n_q)) |-> ##[0:1] !o_excite)
    else $error("slow excitation removal");
  a_unlatched_off: assert property (@(posedge i_clk) disable iff (i_srst)
    !cfg_done_q |=> !o_excite)
    else $error("excitation before settings captured");
  a_auto_ignore: assert property (@(posedge i_clk) disable iff (i_srst)
    (sed_is_auto(son_mode_q) && !i_servo_ready) |=> !o_excite)
    else $error("auto mode excited without ready");
  a_ref_pass: assert property (@(posedge i_clk) disable iff (i_srst)
    (run_ok && i_ref_valid) |=> o_ref_valid)
    else $error("reference blocked while powered");
  a_ref_block: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_ref_valid |=> !o_ref_valid)
    else $error("reference passed without request");

  // Main scenarios reached
  c_ext_on: cover property (@(posedge i_clk) disable iff (i_srst)
    son_mode_q == SED_SON_EXTERNAL && o_excite);
  c_auto_on: cover property (@(posedge i_clk) disable iff (i_srst)
    son_mode_q == SED_SON_AUTOMATIC && o_excite);
  c_turn_off: cover property (@(posedge i_clk) disable iff (i_srst) $fell(o_excite));
  c_reversed: cover property (@(posedge i_clk) disable iff (i_srst) dir_rev_q && o_ref_valid);
  c_auto_term_high: cover property (@(posedge i_clk) disable iff (i_srst)
    sed_is_auto(son_mode_q) && son_n_q && o_excite);

endmodule

// ---- sed_host_model.sv ----
// Host controller model: drives the enable terminals and the motion reference.
// Assumes the bench commands it by level and that it shares the drive clock.
`timescale 1ns/10ps
module sed_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_en,
  input  wire logic [2:0] i_sel,
  input  wire logic       i_go,
  input  wire logic       i_excite,
  output logic [7:0]      o_term_n,
  output logic            o_ref_valid
);
  // Idle terminals rest high on pull-ups; only the chosen one is pulled low
  always_ff @(posedge i_clk) begin
    o_term_n <= ~(8'(i_en) << i_sel);
  end
  // Reference is sent only once motor power is seen, so enable always comes first
  always_ff @(posedge i_clk) begin
    o_ref_valid <= i_go && i_excite;
  end
endmodule

// ---- servo_enable_and_direction_tb_top.sv ----
// Testbench for the servo enable block: external and automatic enable, direction.
// Assumes the host model drives terminals and references; bench drives the rest.
`timescale 1ns/10ps
module servo_enable_and_direction_tb_top;
  import sed_pkg::*;
  logic        i_clk = 0, i_srst = 1, i_servo_ready = 0, i_ref_fwd = 0;
  logic        i_enc_a = 0, i_enc_b = 0, i_mon_sign = 0, en = 0, go = 0;
  logic [15:0] i_basic_function_select = 16'h0000;
  logic [2:0]  i_son_term_sel = 3'h0, sel = 3'h0;
  logic [7:0]  i_term_n;
  logic        i_ref_valid, o_excite, o_ref_valid, o_ccw, o_enc_a, o_enc_b, o_mon_sign;
  int          num_errors = 0, n_compared = 0, cyc = 0;
  // Clock generation and hang guard
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      test_done();
    end
  end
  sed_host_model sed_host_model_inst (.i_clk(i_clk), .i_en(en), .i_sel(sel), .i_go(go),
    .i_excite(o_excite), .o_term_n(i_term_n), .o_ref_valid(i_ref_valid));
  sed_servo_enable sed_servo_enable_inst (.i_clk(i_clk), .i_srst(i_srst),
    .i_basic_function_select(i_basic_function_select), .i_son_term_sel(i_son_term_sel),
    .i_term_n(i_term_n), .i_servo_ready(i_servo_ready), .i_ref_fwd(i_ref_fwd),
    .i_ref_valid(i_ref_valid), .i_enc_a(i_enc_a), .i_enc_b(i_enc_b), .i_mon_sign(i_mon_sign),
    .o_excite(o_excite), .o_ref_valid(o_ref_valid), .o_ccw(o_ccw), .o_enc_a(o_enc_a),
    .o_enc_b(o_enc_b), .o_mon_sign(o_mon_sign));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Reset with given settings, then scramble them once they are latched
  task automatic rst(input logic [15:0] s, input logic [2:0] t, input logic rdy);
    @(posedge i_clk);
    i_srst <= 1;
    i_basic_function_select <= s;
    i_son_term_sel <= t;
    sel <= t;
    en <= 0;
    go <= 0;
    i_servo_ready <= rdy;
    repeat (4) @(posedge i_clk);
    i_srst <= 0;
    @(posedge i_clk);
    i_basic_function_select <= s ^ 16'h0011;
    i_son_term_sel <= t + 3'h1;
  endtask
  // External enable on terminal t with direction bit rev
  task automatic ext_run(input logic [2:0] t, input logic rev);
    rst({11'h000, rev, 4'h0}, t, 1'b1);
    @(posedge i_clk);
    en <= 1;
    i_ref_fwd <= 1;
    tick(3);
    chk(o_excite, 0);
    tick(1);
    chk(o_excite, 1);
    @(posedge i_clk);
    go <= 1;
    i_enc_a <= 1;
    i_enc_b <= rev;
    i_mon_sign <= 1;
    tick(2);
    chk(o_ref_valid, 1);
    chk(o_ccw, {7'h00, !rev});
    chk({5'h00, o_enc_a, o_enc_b, o_mon_sign}, {5'h00, 1'b1, rev, 1'b1});
    @(posedge i_clk);
    en <= 0;
    go <= 0;
    i_ref_fwd <= 0;
    tick(2);
    chk(o_excite, 1);
    tick(1);
    chk(o_excite, 0);
    chk(o_ref_valid, 0);
    chk(o_ccw, {7'h00, rev});
  endtask
  // Automatic enable: terminal stays high, excitation follows ready
  task automatic auto_run;
    rst(16'h0001, 3'h0, 1'b0);
    @(posedge i_clk);
    i_servo_ready <= 1;
    tick(1);
    chk(o_excite, 0);
    tick(1);
    chk(o_excite, 1);
  endtask
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    ext_run(3'h0, 1'b0);
    ext_run(3'h5, 1'b1);
    auto_run();
    test_done();
  end
endmodule
